// >>> hw/cax_consts.svh
// Register offsets, field positions and reset values of the ALU subset block
`ifndef CAX_CONSTS_SVH
`define CAX_CONSTS_SVH

// Byte offsets of the register words
`define CAX_OFF_INSTR 12'h000
`define CAX_OFF_ACC 12'h004
`define CAX_OFF_STATUS 12'h008
`define CAX_OFF_DIR_A 12'h00C
`define CAX_OFF_DIR_B 12'h010
`define CAX_OFF_DIR_C 12'h014
`define CAX_OFF_WDOG 12'h018
`define CAX_OFF_PRESC 12'h01C
// File register window: byte address BASE + 4 * index
`define CAX_FILE_BASE 12'h200
`define CAX_FILE_TOP 12'h3FC

// Status bit positions
`define CAX_ST_CARRY 0
`define CAX_ST_NIBBLE 1
`define CAX_ST_ZERO 2
`define CAX_ST_PDOWN 3
`define CAX_ST_EXPIRY 4

// Direction load operands
`define CAX_DIR_SEL_A 7'h05
`define CAX_DIR_SEL_B 7'h06
`define CAX_DIR_SEL_C 7'h07

// Reset values
`define CAX_ACC_RST 8'h00
`define CAX_DIR_RST 8'hFF
`define CAX_FILE_RST 8'h00
`define CAX_WDOG_CLR 8'h00
`define CAX_STATUS_RST 5'h18

`endif

// >>> hw/cax_pkg.sv
// Types shared by the ALU subset block
package cax_pkg;

    typedef enum logic [3:0] {
        CAX_OP_NOP = 4'b0000,
        CAX_OP_ROTATE_RIGHT_CARRY = 4'b0001,
        CAX_OP_LITERAL_MINUS_ACC = 4'b0010,
        CAX_OP_REG_MINUS_ACC = 4'b0011,
        CAX_OP_REG_MINUS_ACC_BORROW = 4'b0100,
        CAX_OP_NIBBLE_EXCHANGE = 4'b0101,
        CAX_OP_DIRECTION_LOAD = 4'b0110,
        CAX_OP_LITERAL_XOR_ACC = 4'b0111,
        CAX_OP_REG_XOR_ACC = 4'b1000,
        CAX_OP_SLEEP = 4'b1001
    } cax_op_t;

    // Instruction word as written to the instruction register
    typedef struct packed {
        logic [7:0] rsv_hi;
        logic [7:0] literal;
        logic rsv_mid;
        logic [6:0] file_adr;
        logic [2:0] rsv_lo;
        logic dest;
        cax_op_t op;
    } cax_instr_t;

    typedef struct packed {
        logic expiry_status_bit;
        logic power_down_bit;
        logic zero;
        logic nibble_borrow_flag;
        logic carry;
    } cax_status_t;

endpackage : cax_pkg

// >>> hw/cax_alu.sv
// Execution datapath for a subset of an 8-bit core's instructions, Wishbone slave
//
// Contract
// - Rotate right through carry: old carry to bit 7, bit 0 to carry.
// - Destination bit 0 writes the accumulator, 1 writes the addressed register.
// - Literal minus accumulator goes to the accumulator, updating carry, nibble flag, zero.
// - Carry clear when subtrahend exceeds minuend; nibble flag likewise on low nibbles.
// - Register minus accumulator goes to the destination, updating carry, nibble flag, zero.
// - Register minus accumulator minus inverted carry goes to destination, flags updated.
// - Nibble exchange swaps register halves into the destination, flags untouched.
// - Direction load copies accumulator into port A, B, C direction for 5, 6, 7.
// - Literal xor accumulator goes to the accumulator, updating only zero.
// - Register xor accumulator goes to the destination, updating only zero.
// - Sleep clears watchdog counter and prescaler, sets expiry, clears power-down.
//
// Design decisions made here: the Wishbone register port and the register addresses.
`timescale 1ns/100ps
`include "cax_consts.svh"

module cax_alu
    import cax_pkg::*;
#(
    parameter int ADR_W = 12,
    parameter int PRESC_W = 8,
    parameter int WDOG_W = 8,
    parameter int FILE_DEPTH = 128
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Port direction registers
    output logic [7:0] port_a_direction_o,
    output logic [7:0] port_b_direction_o,
    output logic [7:0] port_c_direction_o,
    // Power status
    output logic power_down_bit_o,
    output logic expiry_status_bit_o
);

    localparam int NUM_DIR = 3;

    // Bus state
    logic ack_q;
    logic [31:0] dat_q;
    logic req;
    logic fire;
    logic wr_fire;
    logic [ADR_W-1:0] word_adr;
    logic in_file;
    logic [6:0] file_idx;
    logic hit_instr;
    logic hit_acc;
    logic hit_status;
    logic byte0_wr;

    // Architectural state
    logic [7:0] acc_q;
    cax_status_t status_q;
    logic [7:0] file_mem [FILE_DEPTH];
    logic [7:0] dir_q [NUM_DIR];
    logic [PRESC_W-1:0] presc_q;
    logic [WDOG_W-1:0] wdog_q;

    // Execution
    cax_instr_t instr;
    logic exec;
    logic [7:0] f_val;
    logic [7:0] result;
    logic wr_acc;
    logic wr_file;
    logic upd_cy;
    logic upd_z;
    logic upd_dc;
    logic new_cy;
    logic new_dc;
    logic do_sleep;
    logic [2:0] dir_hit;
    logic [7:0] minuend;
    logic [7:0] subtrahend;
    logic borrow_in;
    logic [8:0] diff9;
    logic [4:0] diff5;
    logic [31:0] rd_mux;

    // Bus decode
    assign req = wb_cyc_i & wb_stb_i;
    assign fire = req & ack_q;
    assign wr_fire = fire & wb_we_i;
    assign word_adr = {wb_adr_i[ADR_W-1:2], 2'b00};
    assign in_file = (word_adr >= `CAX_FILE_BASE) && (word_adr <= `CAX_FILE_TOP);
    assign file_idx = wb_adr_i[8:2];
    assign hit_instr = (word_adr == `CAX_OFF_INSTR);
    assign hit_acc = (word_adr == `CAX_OFF_ACC);
    assign hit_status = (word_adr == `CAX_OFF_STATUS);
    // Eight-bit registers take only byte lane 0; other lanes are dropped
    assign byte0_wr = wr_fire && wb_sel_i[0];

    assign instr = cax_instr_t'(wb_dat_i);
    // Instruction runs at the acknowledging edge, full-word writes only; a partial
    // write to the instruction word is dropped so a torn opcode never executes
    assign exec = wr_fire && hit_instr && (wb_sel_i == 4'hF);
    assign f_val = file_mem[instr.file_adr];

    // Shared subtractor: minuend - subtrahend - borrow_in
    always_comb begin
        minuend = f_val;
        subtrahend = acc_q;
        borrow_in = 1'b0;
        case (instr.op)
            CAX_OP_LITERAL_MINUS_ACC: begin
                minuend = instr.literal;
            end
            CAX_OP_REG_MINUS_ACC_BORROW: begin
                borrow_in = ~status_q.carry;
            end
            default: begin
                minuend = f_val;
            end
        endcase
    end

    // Bit 8 and bit 4 carry the full and low-nibble borrows out
    assign diff9 = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrow_in};
    assign diff5 = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]} - {4'h0, borrow_in};

    // Result, destination and flag selection per instruction
    // Undefined opcodes fall to the default branch and change nothing
    always_comb begin
        result = 8'h00;
        wr_acc = 1'b0;
        wr_file = 1'b0;
        upd_cy = 1'b0;
        upd_z = 1'b0;
        upd_dc = 1'b0;
        new_cy = status_q.carry;
        new_dc = status_q.nibble_borrow_flag;
        do_sleep = 1'b0;
        dir_hit = 3'b000;
        case (instr.op)
            CAX_OP_ROTATE_RIGHT_CARRY: begin
                result = {status_q.carry, f_val[7:1]};
                new_cy = f_val[0];
                upd_cy = 1'b1;
                wr_acc = ~instr.dest;
                wr_file = instr.dest;
            end
            CAX_OP_LITERAL_MINUS_ACC: begin
                result = diff9[7:0];
                new_cy = ~diff9[8];
                new_dc = ~diff5[4];
                upd_cy = 1'b1;
                upd_dc = 1'b1;
                upd_z = 1'b1;
                wr_acc = 1'b1;
            end
            CAX_OP_REG_MINUS_ACC: begin
                result = diff9[7:0];
                new_cy = ~diff9[8];
                new_dc = ~diff5[4];
                upd_cy = 1'b1;
                upd_dc = 1'b1;
                upd_z = 1'b1;
                wr_acc = ~instr.dest;
                wr_file = instr.dest;
            end
            CAX_OP_REG_MINUS_ACC_BORROW: begin
                result = diff9[7:0];
                new_cy = ~diff9[8];
                new_dc = ~diff5[4];
                upd_cy = 1'b1;
                upd_dc = 1'b1;
                upd_z = 1'b1;
                wr_acc = ~instr.dest;
                wr_file = instr.dest;
            end
            CAX_OP_NIBBLE_EXCHANGE: begin
                result = {f_val[3:0], f_val[7:4]};
                wr_acc = ~instr.dest;
                wr_file = instr.dest;
            end
            CAX_OP_DIRECTION_LOAD: begin
                dir_hit[0] = (instr.file_adr == `CAX_DIR_SEL_A);
                dir_hit[1] = (instr.file_adr == `CAX_DIR_SEL_B);
                dir_hit[2] = (instr.file_adr == `CAX_DIR_SEL_C);
            end
            CAX_OP_LITERAL_XOR_ACC: begin
                result = acc_q ^ instr.literal;
                upd_z = 1'b1;
                wr_acc = 1'b1;
            end
            CAX_OP_REG_XOR_ACC: begin
                result = acc_q ^ f_val;
                upd_z = 1'b1;
                wr_acc = ~instr.dest;
                wr_file = instr.dest;
            end
            CAX_OP_SLEEP: begin
                do_sleep = 1'b1;
            end
            default: begin
                result = 8'h00;
            end
        endcase
    end

    // Wishbone acknowledge: one cycle after the strobe, dropped the cycle after
    // A held strobe sees ack alternate, so no access is taken twice in a row
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // Read data mux; unmapped addresses read as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (in_file) begin
            rd_mux = {24'h000000, file_mem[file_idx]};
        end else begin
            case (word_adr)
                `CAX_OFF_ACC: rd_mux = {24'h000000, acc_q};
                `CAX_OFF_STATUS: rd_mux = {27'h0000000, status_q};
                `CAX_OFF_DIR_A: rd_mux = {24'h000000, dir_q[0]};
                `CAX_OFF_DIR_B: rd_mux = {24'h000000, dir_q[1]};
                `CAX_OFF_DIR_C: rd_mux = {24'h000000, dir_q[2]};
                `CAX_OFF_WDOG: rd_mux = 32'(wdog_q);
                `CAX_OFF_PRESC: rd_mux = 32'(presc_q);
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // Data is captured on the edge that raises ack, so it stands through the ack cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= 32'h0000_0000;
        end else if (req & ~ack_q) begin
            dat_q <= rd_mux;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // Accumulator
    // Bus loads and executed results use different addresses and never meet
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_q <= `CAX_ACC_RST;
        end else if (exec && wr_acc) begin
            acc_q <= result;
        end else if (byte0_wr && hit_acc) begin
            acc_q <= wb_dat_i[7:0];
        end
    end

    // Status flags
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_q <= cax_status_t'(`CAX_STATUS_RST);
        end else if (exec) begin
            // Each flag moves only when the executing instruction owns it
            if (upd_dc) begin
                status_q.nibble_borrow_flag <= new_dc;
            end
            if (upd_cy) begin
                status_q.carry <= new_cy;
            end
            if (upd_z) begin
                status_q.zero <= (result == 8'h00);
            end
            if (do_sleep) begin
                status_q.expiry_status_bit <= 1'b1;
                status_q.power_down_bit <= 1'b0;
            end
        end else if (byte0_wr && hit_status) begin
            status_q <= cax_status_t'(wb_dat_i[4:0]);
        end
    end

    // File registers
    // Reset clears every entry so reads never return unknown values
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < FILE_DEPTH; i++) begin
                file_mem[i] <= `CAX_FILE_RST;
            end
        end else if (exec && wr_file) begin
            file_mem[instr.file_adr] <= result;
        end else if (byte0_wr && in_file) begin
            file_mem[file_idx] <= wb_dat_i[7:0];
        end
    end

    // Direction registers, one per port
    // Operands outside the three port selectors load nothing
    for (genvar g = 0; g < NUM_DIR; g++) begin : g_dir
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                dir_q[g] <= `CAX_DIR_RST;
            end else if (exec && dir_hit[g]) begin
                dir_q[g] <= acc_q;
            end
        end
    end

    assign port_a_direction_o = dir_q[0];
    assign port_b_direction_o = dir_q[1];
    assign port_c_direction_o = dir_q[2];
    assign power_down_bit_o = status_q.power_down_bit;
    assign expiry_status_bit_o = status_q.expiry_status_bit;

    // Watchdog prescaler and counter, free running
    // The counter steps once per full prescaler turn; nothing acts on its value here
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            presc_q <= '0;
        end else if (exec && do_sleep) begin
            presc_q <= '0;
        end else begin
            presc_q <= presc_q + PRESC_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdog_q <= WDOG_W'(`CAX_WDOG_CLR);
        end else if (exec && do_sleep) begin
            wdog_q <= WDOG_W'(`CAX_WDOG_CLR);
        end else if (&presc_q) begin
            wdog_q <= wdog_q + WDOG_W'(1);
        end
    end

endmodule : cax_alu

// >>> dv/cax_alu_asserts.sv
// Port-level assertions for the ALU subset block
`timescale 1ns/100ps
module cax_alu_asserts #(
    parameter int ADR_W = 12
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Directions and power status
    input wire logic [7:0] port_a_direction_o,
    input wire logic [7:0] port_b_direction_o,
    input wire logic [7:0] port_c_direction_o,
    input wire logic power_down_bit_o,
    input wire logic expiry_status_bit_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic ins_wr;
    logic st_wr;
    logic slp;
    logic rd_ack;
    logic dir_ld;
    assign ins_wr = wb_ack_o && wb_we_i && wb_adr_i[ADR_W-1:2] == '0 && wb_sel_i == 4'hF;
    assign st_wr = wb_ack_o && wb_we_i && wb_adr_i == ADR_W'(12'h008) && wb_sel_i[0];
    assign slp = ins_wr && wb_dat_i[3:0] == 4'h9;
    assign rd_ack = wb_ack_o && !wb_we_i;
    assign dir_ld = ins_wr && wb_dat_i[3:0] == 4'h6;
    a_dir_a_load: assert property ($changed(port_a_direction_o) |->
        $past(dir_ld && wb_dat_i[14:8] == 7'h05))
        else $error("port A direction changed without its load");
    a_dir_b_load: assert property ($changed(port_b_direction_o) |->
        $past(dir_ld && wb_dat_i[14:8] == 7'h06))
        else $error("port B direction changed without its load");
    a_dir_c_load: assert property ($changed(port_c_direction_o) |->
        $past(dir_ld && wb_dat_i[14:8] == 7'h07))
        else $error("port C direction changed without its load");
    a_sleep_status: assert property (slp |=> expiry_status_bit_o && !power_down_bit_o)
        else $error("sleep did not set expiry and clear power-down");
    a_pdown_cause: assert property ($fell(power_down_bit_o) |->
        $past(slp || st_wr && !wb_dat_i[3]))
        else $error("power-down cleared without cause");
    a_expiry_cause: assert property ($rose(expiry_status_bit_o) |->
        $past(slp || st_wr && wb_dat_i[4]))
        else $error("expiry set without cause");
    a_dir_read: assert property (rd_ack && wb_adr_i == ADR_W'(12'h00C) |->
        wb_dat_o == {24'h0, port_a_direction_o})
        else $error("direction read differs from port");
    a_status_read: assert property (rd_ack && wb_adr_i == ADR_W'(12'h008) |->
        wb_dat_o[31:3] == {27'h0, expiry_status_bit_o, power_down_bit_o})
        else $error("status read differs from power bits");
    a_ack_once: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("acknowledge not a single pulse one cycle late");
    c_sleep: cover property (slp);
    c_dir_a: cover property ($changed(port_a_direction_o));
    c_status_rd: cover property (rd_ack && wb_adr_i == ADR_W'(12'h008));
endmodule : cax_alu_asserts

bind cax_alu cax_alu_asserts #(.ADR_W(ADR_W)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .port_a_direction_o(port_a_direction_o), .port_b_direction_o(port_b_direction_o),
    .port_c_direction_o(port_c_direction_o), .power_down_bit_o(power_down_bit_o),
    .expiry_status_bit_o(expiry_status_bit_o));

// >>> dv/cax_alu_tb.sv
// Self-checking testbench for the ALU subset block
`timescale 1ns/100ps
`include "cax_consts.svh"
module cax_alu_tb import cax_pkg::*;;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [3:0] sel = 4'hF;
    logic [31:0] dat = 32'h0, rdat, dat_o;
    logic ack, pd, ex;
    logic [7:0] pa, pb, pc;
    int failures = 0, checked = 0, cycles = 0;
    always #5 clk_i = ~clk_i;
    cax_alu u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .port_a_direction_o(pa), .port_b_direction_o(pb),
        .port_c_direction_o(pc), .power_down_bit_o(pd), .expiry_status_bit_o(ex));
    task complete_run;
        $display("failures %0d checked %0d", failures, checked);
        if (failures == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            complete_run;
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task rd(input logic [11:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask : rd
    task exe(input cax_op_t op, input logic d, input logic [6:0] f, input logic [7:0] k);
        wb(1'b1, `CAX_OFF_INSTR, {8'h00, k, 1'b0, f, 3'b000, d, op});
    endtask : exe
    function automatic logic [11:0] fa(input logic [6:0] f);
        return `CAX_FILE_BASE + {3'b000, f, 2'b00};
    endfunction : fa
    task t_reset;
        rd(`CAX_OFF_STATUS, 32'h18);
        rd(`CAX_OFF_DIR_B, 32'hFF);
        rd(12'h100, 32'h0);
    endtask : t_reset
    task t_rotate;
        wb(1'b1, fa(3), 32'h81);
        wb(1'b1, `CAX_OFF_STATUS, 32'h1D);
        exe(CAX_OP_ROTATE_RIGHT_CARRY, 1'b1, 7'd3, 8'h00);
        rd(fa(3), 32'hC0);
        rd(`CAX_OFF_STATUS, 32'h1D);
        exe(CAX_OP_ROTATE_RIGHT_CARRY, 1'b0, 7'd3, 8'h00);
        rd(`CAX_OFF_ACC, 32'hE0);
        rd(fa(3), 32'hC0);
        rd(`CAX_OFF_STATUS, 32'h1C);
    endtask : t_rotate
    // Result and flags worked out from nine-bit and five-bit differences
    task do_sub(input cax_op_t op, input logic [7:0] a, input logic [7:0] w, input logic c);
        logic b;
        logic [8:0] s;
        logic [4:0] n;
        logic [11:0] dst;
        b = (op == CAX_OP_REG_MINUS_ACC_BORROW) ? !c : 1'b0;
        s = {1'b0, a} - {1'b0, w} - 9'(b);
        n = {1'b0, a[3:0]} - {1'b0, w[3:0]} - 5'(b);
        wb(1'b1, `CAX_OFF_ACC, {24'h0, w});
        wb(1'b1, fa(9), {24'h0, a});
        wb(1'b1, `CAX_OFF_STATUS, {27'h3, s[7:0] != 8'h00, n[4], c});
        exe(op, 1'b1, 7'd9, a);
        dst = (op == CAX_OP_LITERAL_MINUS_ACC) ? `CAX_OFF_ACC : fa(9);
        rd(dst, {24'h0, s[7:0]});
        rd(`CAX_OFF_STATUS, {27'h3, s[7:0] == 8'h00, !n[4], !s[8]});
    endtask : do_sub
    task t_sub;
        do_sub(CAX_OP_LITERAL_MINUS_ACC, 8'h05, 8'h05, 1'b1);
        do_sub(CAX_OP_LITERAL_MINUS_ACC, 8'h03, 8'h04, 1'b1);
        do_sub(CAX_OP_REG_MINUS_ACC, 8'h10, 8'h01, 1'b0);
        do_sub(CAX_OP_REG_MINUS_ACC, 8'h44, 8'h44, 1'b0);
        do_sub(CAX_OP_REG_MINUS_ACC_BORROW, 8'h44, 8'h44, 1'b0);
        do_sub(CAX_OP_REG_MINUS_ACC_BORROW, 8'h44, 8'h43, 1'b0);
        do_sub(CAX_OP_REG_MINUS_ACC_BORROW, 8'h20, 8'h0F, 1'b1);
    endtask : t_sub
    task t_swap_xor;
        wb(1'b1, fa(5), 32'h3C);
        wb(1'b1, `CAX_OFF_STATUS, 32'h1B);
        exe(CAX_OP_NIBBLE_EXCHANGE, 1'b0, 7'd5, 8'h00);
        rd(`CAX_OFF_ACC, 32'hC3);
        exe(CAX_OP_NIBBLE_EXCHANGE, 1'b1, 7'd5, 8'h00);
        rd(fa(5), 32'hC3);
        rd(`CAX_OFF_STATUS, 32'h1B);
        exe(CAX_OP_LITERAL_XOR_ACC, 1'b0, 7'd0, 8'hC3);
        rd(`CAX_OFF_ACC, 32'h00);
        rd(`CAX_OFF_STATUS, 32'h1F);
        exe(CAX_OP_REG_XOR_ACC, 1'b0, 7'd5, 8'h00);
        rd(`CAX_OFF_ACC, 32'hC3);
        rd(`CAX_OFF_STATUS, 32'h1B);
        exe(CAX_OP_REG_XOR_ACC, 1'b1, 7'd5, 8'h00);
        rd(fa(5), 32'h00);
        rd(`CAX_OFF_STATUS, 32'h1F);
    endtask : t_swap_xor
    task t_dir;
        for (int i = 4; i < 8; i++) begin
            wb(1'b1, `CAX_OFF_ACC, 32'(32'h50 + i));
            exe(CAX_OP_DIRECTION_LOAD, 1'b0, 7'(i), 8'h00);
        end
        // Direction outputs settle just after the acknowledging edge
        @(posedge clk_i);
        chk({8'h0, pa, pb, pc}, 32'h0055_5657);
        rd(`CAX_OFF_DIR_A, 32'h55);
        rd(`CAX_OFF_DIR_C, 32'h57);
        rd(`CAX_OFF_STATUS, 32'h1F);
    endtask : t_dir
    task t_sleep;
        wb(1'b1, `CAX_OFF_STATUS, 32'h08);
        repeat (520) @(posedge clk_i);
        // The counter must have moved, or its clearing below proves nothing
        wb(1'b0, `CAX_OFF_WDOG, 32'h0);
        chk(32'(rdat != 32'h0), 32'h1);
        exe(CAX_OP_SLEEP, 1'b0, 7'd0, 8'h00);
        @(posedge clk_i);
        chk({30'h0, ex, pd}, 32'h2);
        rd(`CAX_OFF_WDOG, 32'h0);
        // Prescaler restarts from zero at the sleep edge and has counted five edges here
        rd(`CAX_OFF_PRESC, 32'h5);
    endtask : t_sleep
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_rotate;
        t_sub;
        t_swap_xor;
        t_dir;
        t_sleep;
        complete_run;
    end
endmodule : cax_alu_tb
